// ==== lst_pkg.sv ====
package lst_pkg;
	// ==========================================
	// clock and cycle timing
	localparam int CRYSTAL_KHZ = 30208;
	localparam int CYCLE_KHZ = 256;
	localparam int SAMPLE_PERIOD_NS = 4000;
	localparam int CYCLE_CLOCKS = CRYSTAL_KHZ / CYCLE_KHZ;
	localparam int INSTR_CLOCKS = 2;
	localparam int INSTR_PER_CYCLE = CYCLE_CLOCKS / INSTR_CLOCKS;
	localparam int RX_BIT_CLOCKS = 4;
	localparam int TX_BIT_CLOCKS = 2;
	localparam int SAMPLE_BITS = 16;
	localparam int RX_WINDOW = SAMPLE_BITS * RX_BIT_CLOCKS;
	localparam int TX_WINDOW = 2 * SAMPLE_BITS * TX_BIT_CLOCKS;
	localparam logic [6:0] CYC_LAST = 7'(CYCLE_CLOCKS - 1);
	localparam logic [6:0] CYC_RX_END = 7'(RX_WINDOW);
	localparam logic [6:0] CYC_TX_END = 7'(TX_WINDOW);
	localparam logic [6:0] CYC_ZERO = 7'h00;
	localparam logic [4:0] TX_SPLIT = 5'(SAMPLE_BITS);
	// ==========================================
	// multiplexing
	localparam int AUX_INPUTS = 4;
	localparam int SLOW_OUTPUTS = 8;
	// ==========================================
	// host write port decode
	localparam logic [3:0] HOST_ADDR_MODE = 4'h0;
	localparam logic [3:0] HOST_ADDR_AUX_CFG = 4'h1;
	localparam logic [7:0] CFG_MODE_RESET = 8'h00;
	localparam logic [7:0] CFG_AUX_RESET = 8'h00;
	localparam int CFG_EXT_REF_BIT = 0;
	// ==========================================
	// phase comparator states
	typedef enum logic [1:0] {
		LST_PD_IDLE = 2'b00,
		LST_PD_UP = 2'b01,
		LST_PD_DOWN = 2'b10
	} lst_pd_state_t;
endpackage : lst_pkg

// ==== lst_shift.sv ====
module lst_shift import lst_pkg::*; #(
	parameter int WIDTH = 8
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	input wire logic shift,
	input wire logic sin,
	output logic sout,
	output logic [WIDTH-1:0] word_q
);
	// ==========================================
	// shift register, parallel load wins over shift
	always_ff @(posedge clock) begin
		if (srst) begin
			word_q <= '0;
		end else if (load) begin
			word_q <= load_data;
		end else if (shift) begin
			word_q <= {word_q[WIDTH-2:0], sin};
		end
	end

	assign sout = word_q[WIDTH-1];
endmodule : lst_shift

// ==== lst_timing.sv ====
// Functional notes
// - internal mode selects the fixed crystal as the whole board clock.
// - 256 kHz converter cycle, 59 two-clock instructions per cycle.
// - external mode switches the system clock to the VCO.
// - phase comparator: conditioned external reference versus sine square wave steers VCO.
// - all converter clocks and mux selects come from the system clock.
// - main samples go to receive port; aux samples into two shift registers.
// - both converter inputs deliver one new sample every cycle.
// - four DAC output values delivered every cycle, one per channel.
// - serial transmit port sends one channel of each DAC per cycle.
// - transmit port clocks at twice the receive bit rate.
// - other DAC channels loaded through two parallel-to-serial registers.
// - sine, X, Y channels; fourth channel cycles through eight slow outputs.
// - sine sample computed every cycle goes to the sine DAC channel.
// - host bus buffers enabled only while host writes this board.
// - host configuration held in latches; decoder makes chip selects and strobes.
// - converter channels sample together; each aux input converted every fourth cycle.
module lst_timing import lst_pkg::*; #(
	parameter int WIDTH = SAMPLE_BITS
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic ext_ref_in,
	input wire logic sine_square_in,
	input wire logic adc_main_sdata,
	input wire logic adc_aux_sdata,
	input wire logic proc_tx_sdata,
	input wire logic proc_wr,
	input wire logic proc_wr_dac,
	input wire logic [WIDTH-1:0] proc_wdata,
	input wire logic host_sel,
	input wire logic host_write,
	input wire logic [3:0] host_addr,
	input wire logic [7:0] host_data,
	output logic clk_sel_vco_q,
	output logic cycle_tick_q,
	output logic instr_tick_q,
	output logic adc_convert_q,
	output logic adc_clock_q,
	output logic [1:0] aux_in_sel_q,
	output logic proc_rx_clock_q,
	output logic proc_rx_frame_q,
	output logic proc_rx_data_q,
	output logic proc_tx_clock_q,
	output logic [WIDTH-1:0] aux_word_q,
	output logic [1:0] aux_word_index_q,
	output logic aux_ready_q,
	output logic dac_sclk_q,
	output logic dac_load_q,
	output logic dac_a_sdata_q,
	output logic dac_b_sdata_q,
	output logic dac_a2_sdata_q,
	output logic dac_b2_sdata_q,
	output logic [2:0] slow_sel_q,
	output logic pll_up_q,
	output logic pll_down_q,
	output logic host_buf_en_q,
	output logic [7:0] cfg_mode_q,
	output logic [7:0] cfg_aux_q,
	output logic [15:0] host_strobe_q
);
	// ==========================================
	// cycle divider
	logic [6:0] cyc_q;
	logic rx_bit;
	logic tx_bit;
	logic [4:0] tx_idx;

	always_ff @(posedge clock) begin
		if (srst || cyc_q == CYC_LAST) begin
			cyc_q <= CYC_ZERO;
		end else begin
			cyc_q <= cyc_q + 7'h01;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cycle_tick_q <= 1'b0;
			instr_tick_q <= 1'b0;
		end else begin
			cycle_tick_q <= (cyc_q == CYC_LAST);
			instr_tick_q <= cyc_q[0];
		end
	end

	assign rx_bit = (cyc_q < CYC_RX_END) && (cyc_q[1:0] == 2'h3);
	assign tx_bit = (cyc_q < CYC_TX_END) && cyc_q[0];
	assign tx_idx = cyc_q[5:1];

	// ==========================================
	// converter clocks and selects
	always_ff @(posedge clock) begin
		if (srst) begin
			adc_convert_q <= 1'b0;
			adc_clock_q <= 1'b0;
			proc_rx_clock_q <= 1'b0;
			proc_rx_frame_q <= 1'b0;
			proc_rx_data_q <= 1'b0;
			proc_tx_clock_q <= 1'b0;
			dac_sclk_q <= 1'b0;
			dac_load_q <= 1'b0;
		end else begin
			adc_convert_q <= (cyc_q == CYC_LAST);
			adc_clock_q <= (cyc_q < CYC_RX_END) && cyc_q[1];
			proc_rx_clock_q <= (cyc_q < CYC_RX_END) && cyc_q[1];
			proc_rx_frame_q <= (cyc_q == CYC_LAST);
			proc_rx_data_q <= adc_main_sdata;
			proc_tx_clock_q <= (cyc_q < CYC_TX_END) && !cyc_q[0];
			dac_sclk_q <= (cyc_q < CYC_TX_END) && !cyc_q[0];
			dac_load_q <= (cyc_q == CYC_TX_END);
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			aux_in_sel_q <= 2'h0;
			slow_sel_q <= 3'h0;
		end else if (cyc_q == CYC_LAST) begin
			aux_in_sel_q <= aux_in_sel_q + 2'h1;
			slow_sel_q <= slow_sel_q + 3'h1;
		end
	end

	// ==========================================
	// aux serial-to-parallel pair
	logic aux_lo_out;
	logic [WIDTH/2-1:0] aux_lo;
	logic [WIDTH/2-1:0] aux_hi;

	lst_shift #(.WIDTH(WIDTH/2)) u_aux_lo (
		.clock(clock),
		.srst(srst),
		.load(1'b0),
		.load_data('0),
		.shift(rx_bit),
		.sin(adc_aux_sdata),
		.sout(aux_lo_out),
		.word_q(aux_lo)
	);

	lst_shift #(.WIDTH(WIDTH/2)) u_aux_hi (
		.clock(clock),
		.srst(srst),
		.load(1'b0),
		.load_data('0),
		.shift(rx_bit),
		.sin(aux_lo_out),
		.sout(),
		.word_q(aux_hi)
	);

	always_ff @(posedge clock) begin
		if (srst) begin
			aux_word_q <= '0;
			aux_word_index_q <= 2'h0;
			aux_ready_q <= 1'b0;
		end else begin
			aux_ready_q <= (cyc_q == CYC_RX_END);
			if (cyc_q == CYC_RX_END) begin
				aux_word_q <= {aux_hi, aux_lo};
				aux_word_index_q <= aux_in_sel_q - 2'h1;
			end
		end
	end

	// ==========================================
	// dac outputs
	logic [WIDTH-1:0] par_a_q;
	logic [WIDTH-1:0] par_b_q;
	logic par_a_out;
	logic par_b_out;
	logic par_shift;

	always_ff @(posedge clock) begin
		if (srst) begin
			par_a_q <= '0;
			par_b_q <= '0;
		end else if (proc_wr) begin
			if (proc_wr_dac) begin
				par_b_q <= proc_wdata;
			end else begin
				par_a_q <= proc_wdata;
			end
		end
	end

	assign par_shift = tx_bit && (tx_idx < TX_SPLIT);

	lst_shift #(.WIDTH(WIDTH)) u_par_a (
		.clock(clock),
		.srst(srst),
		.load(cyc_q == CYC_LAST),
		.load_data(par_a_q),
		.shift(par_shift),
		.sin(1'b0),
		.sout(par_a_out),
		.word_q()
	);

	lst_shift #(.WIDTH(WIDTH)) u_par_b (
		.clock(clock),
		.srst(srst),
		.load(cyc_q == CYC_LAST),
		.load_data(par_b_q),
		.shift(par_shift),
		.sin(1'b0),
		.sout(par_b_out),
		.word_q()
	);

	// serial port: first word sine to dac a, second word Y to dac b
	always_ff @(posedge clock) begin
		if (srst) begin
			dac_a_sdata_q <= 1'b0;
			dac_b_sdata_q <= 1'b0;
			dac_a2_sdata_q <= 1'b0;
			dac_b2_sdata_q <= 1'b0;
		end else begin
			if (tx_bit && tx_idx < TX_SPLIT) begin
				dac_a_sdata_q <= proc_tx_sdata;
				dac_a2_sdata_q <= par_a_out;
				dac_b2_sdata_q <= par_b_out;
			end
			if (tx_bit && tx_idx >= TX_SPLIT) begin
				dac_b_sdata_q <= proc_tx_sdata;
			end
		end
	end

	// ==========================================
	// phase comparator
	logic [1:0] ref_sync_q;
	logic [1:0] sq_sync_q;
	logic ref_d_q;
	logic sq_d_q;
	logic ref_rise;
	logic sq_rise;
	lst_pd_state_t pd_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			ref_sync_q <= 2'b00;
			sq_sync_q <= 2'b00;
			ref_d_q <= 1'b0;
			sq_d_q <= 1'b0;
		end else begin
			ref_sync_q <= {ref_sync_q[0], ext_ref_in};
			sq_sync_q <= {sq_sync_q[0], sine_square_in};
			ref_d_q <= ref_sync_q[1];
			sq_d_q <= sq_sync_q[1];
		end
	end

	assign ref_rise = ref_sync_q[1] && !ref_d_q;
	assign sq_rise = sq_sync_q[1] && !sq_d_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			pd_q <= LST_PD_IDLE;
		end else begin
			case (pd_q)
				LST_PD_IDLE: begin
					if (ref_rise && !sq_rise) begin
						pd_q <= LST_PD_UP;
					end else if (sq_rise && !ref_rise) begin
						pd_q <= LST_PD_DOWN;
					end
				end
				LST_PD_UP: begin
					if (sq_rise) begin
						pd_q <= LST_PD_IDLE;
					end
				end
				LST_PD_DOWN: begin
					if (ref_rise) begin
						pd_q <= LST_PD_IDLE;
					end
				end
				default: begin
					pd_q <= LST_PD_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			pll_up_q <= 1'b0;
			pll_down_q <= 1'b0;
		end else begin
			pll_up_q <= (pd_q == LST_PD_UP);
			pll_down_q <= (pd_q == LST_PD_DOWN);
		end
	end

	// ==========================================
	// host write port
	logic [1:0] sel_sync_q;
	logic [1:0] wr_sync_q;
	logic [3:0] addr_s1_q;
	logic [3:0] addr_s2_q;
	logic [7:0] data_s1_q;
	logic [7:0] data_s2_q;
	logic wr_d_q;
	logic host_take;

	always_ff @(posedge clock) begin
		if (srst) begin
			sel_sync_q <= 2'b00;
			wr_sync_q <= 2'b00;
			addr_s1_q <= 4'h0;
			addr_s2_q <= 4'h0;
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
			wr_d_q <= 1'b0;
		end else begin
			sel_sync_q <= {sel_sync_q[0], host_sel};
			wr_sync_q <= {wr_sync_q[0], host_write};
			addr_s1_q <= host_addr;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= host_data;
			data_s2_q <= data_s1_q;
			wr_d_q <= wr_sync_q[1] && sel_sync_q[1];
		end
	end

	assign host_take = wr_sync_q[1] && sel_sync_q[1] && !wr_d_q;

	always_ff @(posedge clock) begin
		if (srst) begin
			host_buf_en_q <= 1'b0;
		end else begin
			host_buf_en_q <= wr_sync_q[1] && sel_sync_q[1];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			cfg_mode_q <= CFG_MODE_RESET;
			cfg_aux_q <= CFG_AUX_RESET;
		end else if (host_take) begin
			if (addr_s2_q == HOST_ADDR_MODE) begin
				cfg_mode_q <= data_s2_q;
			end
			if (addr_s2_q == HOST_ADDR_AUX_CFG) begin
				cfg_aux_q <= data_s2_q;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			host_strobe_q <= 16'h0000;
		end else begin
			host_strobe_q <= host_take ? (16'h0001 << addr_s2_q) : 16'h0000;
		end
	end

	// ==========================================
	// clock source select
	always_ff @(posedge clock) begin
		if (srst) begin
			clk_sel_vco_q <= 1'b0;
		end else begin
			clk_sel_vco_q <= cfg_mode_q[CFG_EXT_REF_BIT];
		end
	end

	// ==========================================
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	cycle_period_a: assert property (cycle_tick_q |-> ##118 cycle_tick_q) else $error("cycle length wrong");
	instr_rate_a: assert property (instr_tick_q |=> !instr_tick_q ##1 instr_tick_q) else $error("instr tick");
	clock_select_a: assert property (##1 clk_sel_vco_q == $past(cfg_mode_q[0])) else $error("clock select");
	convert_once_a: assert property (adc_convert_q |=> !adc_convert_q [*8]) else $error("convert");
	aux_select_a: assert property (cycle_tick_q |-> aux_in_sel_q == $past(aux_in_sel_q) + 2'h1) else $error("aux sel");
	slow_select_a: assert property (cycle_tick_q |-> slow_sel_q == $past(slow_sel_q) + 3'h1) else $error("slow sel");
	rx_clock_a: assert property ($rose(proc_rx_clock_q) |-> ##1 proc_rx_clock_q ##1 !proc_rx_clock_q) else $error("rx");
	tx_clock_a: assert property ($rose(proc_tx_clock_q) |=> !proc_tx_clock_q ##1 proc_tx_clock_q || dac_load_q)
		else $error("tx");
	aux_ready_a: assert property (aux_ready_q |-> ##118 aux_ready_q) else $error("aux ready");
	dac_load_a: assert property (dac_load_q |-> ##118 dac_load_q) else $error("dac load");
	buffer_enable_a: assert property (host_strobe_q != 16'h0000 |-> host_buf_en_q) else $error("buf en");
	phase_excl_a: assert property (!(pll_up_q && pll_down_q)) else $error("up and down");

	ext_mode_c: cover property ($rose(clk_sel_vco_q));
	aux_last_c: cover property (aux_ready_q && aux_in_sel_q == 2'h3);
	host_cfg_c: cover property (host_strobe_q[0]);
	pll_up_c: cover property ($rose(pll_up_q));
endmodule : lst_timing

// ==== lst_adc_model.sv ====
module lst_adc_model import lst_pkg::*; (
	input wire logic clock,
	input wire logic srst,
	input wire logic convert,
	input wire logic [15:0] aux_word,
	output logic main_sdata,
	output logic aux_sdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [6:0] bit_cnt_q;
	logic [15:0] word_q;
	logic idle_q;
	// ==========================================
	// frame position, restarted by the shared convert strobe
	always_ff @(posedge clock) begin
		if (srst)
			bit_cnt_q <= 7'h7f;
		else if (convert)
			bit_cnt_q <= 7'h01;
		else if (bit_cnt_q != 7'h7f)
			bit_cnt_q <= bit_cnt_q + 7'h01;
	end
	always_ff @(posedge clock) begin
		if (convert)
			word_q <= aux_word;
	end
	always_ff @(posedge clock) begin
		if (srst)
			idle_q <= 1'b0;
		else
			idle_q <= ~idle_q;
	end
	// ==========================================
	// aux msb first, main lsb first, one bit per four clocks
	always_comb begin
		if (bit_cnt_q < 7'h40) begin
			aux_sdata = word_q[4'hf - bit_cnt_q[5:2]];
			main_sdata = word_q[bit_cnt_q[5:2]];
		end else begin
			// released lines toggle
			aux_sdata = idle_q;
			main_sdata = ~idle_q;
		end
	end
endmodule : lst_adc_model

// ==== lst_timing_tb.sv ====
module lst_timing_tb import lst_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] AUX_WORDS [4] = '{16'ha53c, 16'h5ac3, 16'hffff, 16'h0001};
	localparam logic [31:0] TX_WORD = 32'hc3a5_0ff1;
	localparam logic [15:0] DA2_WORD = 16'h9c36;
	localparam logic [15:0] DB2_WORD = 16'h61e5;
	logic clock, srst, ext_ref_in, sine_square_in, adc_main_sdata, adc_aux_sdata, proc_tx_sdata;
	logic proc_wr, proc_wr_dac, host_sel, host_write;
	logic [15:0] proc_wdata, aux_word_q, aux_tx, host_strobe_q, strobe_acc;
	logic [3:0] host_addr;
	logic [7:0] host_data, cfg_mode_q, cfg_aux_q;
	logic clk_sel_vco_q, cycle_tick_q, instr_tick_q, adc_convert_q, adc_clock_q, proc_rx_clock_q;
	logic proc_rx_frame_q, proc_rx_data_q, proc_tx_clock_q, aux_ready_q, dac_sclk_q, dac_load_q;
	logic dac_a_sdata_q, dac_b_sdata_q, dac_a2_sdata_q, dac_b2_sdata_q, pll_up_q, pll_down_q, host_buf_en_q;
	logic [1:0] aux_in_sel_q, aux_word_index_q;
	logic [2:0] slow_sel_q;
	logic [6:0] tcyc;
	logic buf_seen;
	int n_mismatch, checks, run_cycles, n_str;
	lst_timing i_lst_timing (.clock, .srst, .ext_ref_in, .sine_square_in, .adc_main_sdata, .adc_aux_sdata,
		.proc_tx_sdata, .proc_wr, .proc_wr_dac, .proc_wdata, .host_sel, .host_write, .host_addr, .host_data,
		.clk_sel_vco_q, .cycle_tick_q, .instr_tick_q, .adc_convert_q, .adc_clock_q, .aux_in_sel_q,
		.proc_rx_clock_q, .proc_rx_frame_q, .proc_rx_data_q, .proc_tx_clock_q, .aux_word_q, .aux_word_index_q,
		.aux_ready_q, .dac_sclk_q, .dac_load_q, .dac_a_sdata_q, .dac_b_sdata_q, .dac_a2_sdata_q,
		.dac_b2_sdata_q, .slow_sel_q, .pll_up_q, .pll_down_q, .host_buf_en_q, .cfg_mode_q, .cfg_aux_q,
		.host_strobe_q);
	lst_adc_model i_lst_adc_model (.clock, .srst, .convert(adc_convert_q), .aux_word(aux_tx),
		.main_sdata(adc_main_sdata), .aux_sdata(adc_aux_sdata));
	// ==========================================
	// clock, cycle position, run limit
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (srst || tcyc == CYC_LAST)
			tcyc <= CYC_ZERO;
		else if (cycle_tick_q)
			tcyc <= 7'h01;
		else
			tcyc <= tcyc + 7'h01;
	end
	always @(posedge clock) begin
		run_cycles = run_cycles + 1;
		if (run_cycles == 10000) begin
			n_mismatch = n_mismatch + 1;
			finish_test();
		end
	end
	// ==========================================
	// shared helpers
	task finish_test;
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : finish_test
	task tick;
		@(posedge clock);
		#1;
	endtask : tick
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks = checks + 1;
		if (got !== exp) begin
			n_mismatch = n_mismatch + 1;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wait_cyc(input logic [6:0] n);
		tick;
		while (tcyc !== n)
			tick;
	endtask : wait_cyc
	task host_access(input logic sel, input logic [3:0] addr, input logic [7:0] data);
		n_str = 0;
		strobe_acc = 16'h0000;
		buf_seen = 1'b0;
		host_sel = sel;
		host_write = 1'b1;
		host_addr = addr;
		host_data = data;
		for (int i = 0; i < 12; i++) begin
			if (i == 6) begin
				host_sel = 1'b0;
				host_write = 1'b0;
			end
			if (i == 7) begin
				host_addr = ~addr;
				host_data = ~data;
			end
			tick;
			strobe_acc = strobe_acc | host_strobe_q;
			n_str = n_str + int'(host_strobe_q[addr]);
			if (i < 6)
				buf_seen = buf_seen | host_buf_en_q;
		end
		chk(host_buf_en_q, 1'b0);
		chk(buf_seen, sel);
		chk(n_str, sel);
		chk(strobe_acc, sel ? 16'h0001 << addr : 16'h0000);
	endtask : host_access
	// ==========================================
	// scenarios
	task check_reset;
		tick;
		chk(cfg_mode_q, CFG_MODE_RESET);
		chk(cfg_aux_q, CFG_AUX_RESET);
		chk(clk_sel_vco_q, 1'b0);
		chk({pll_up_q, pll_down_q}, 2'b00);
	endtask : check_reset
	task check_cycle_counts;
		int n_tick, n_conv, n_same, n_load, n_instr, r_rx, r_tx, r_adc, r_sclk;
		logic p_rx, p_tx, p_adc, p_sclk;
		{n_tick, n_conv, n_same, n_load, n_instr, r_rx, r_tx, r_adc, r_sclk} = '0;
		{p_rx, p_tx, p_adc, p_sclk} = 4'h0;
		wait_cyc(CYC_ZERO);
		for (int i = 0; i < CYCLE_CLOCKS; i++) begin
			n_tick += int'(cycle_tick_q);
			n_conv += int'(adc_convert_q);
			n_same += int'(cycle_tick_q & adc_convert_q & proc_rx_frame_q);
			n_load += int'(dac_load_q);
			n_instr += int'(instr_tick_q);
			r_rx += int'(proc_rx_clock_q & ~p_rx);
			r_tx += int'(proc_tx_clock_q & ~p_tx);
			r_adc += int'(adc_clock_q & ~p_adc);
			r_sclk += int'(dac_sclk_q & ~p_sclk);
			{p_rx, p_tx, p_adc, p_sclk} = {proc_rx_clock_q, proc_tx_clock_q, adc_clock_q, dac_sclk_q};
			tick;
		end
		chk(n_tick, 1);
		chk(n_conv, 1);
		chk(n_same, 1);
		chk(n_load, 1);
		chk(n_instr, INSTR_PER_CYCLE);
		chk(r_rx, SAMPLE_BITS);
		chk(r_adc, SAMPLE_BITS);
		chk(r_tx, 2 * SAMPLE_BITS);
		chk(r_sclk, 2 * SAMPLE_BITS);
	endtask : check_cycle_counts
	task check_mux;
		logic [2:0] slow_prev;
		logic [1:0] aux_prev;
		wait_cyc(7'h3c);
		{slow_prev, aux_prev} = {slow_sel_q, aux_in_sel_q};
		repeat (SLOW_OUTPUTS) begin
			wait_cyc(7'h3c);
			chk(slow_sel_q, 3'(slow_prev + 3'h1));
			chk(aux_in_sel_q, 2'(aux_prev + 2'h1));
			{slow_prev, aux_prev} = {slow_sel_q, aux_in_sel_q};
		end
	endtask : check_mux
	task check_aux;
		logic [1:0] idx_prev;
		logic main_prev;
		for (int w = 0; w < 4; w++) begin
			aux_tx = AUX_WORDS[w];
			wait_cyc(CYC_ZERO);
			for (int i = 0; i < CYCLE_CLOCKS; i++) begin
				if (aux_ready_q === 1'b1)
					break;
				main_prev = adc_main_sdata;
				tick;
				chk(proc_rx_data_q, main_prev);
			end
			chk(aux_ready_q, 1'b1);
			chk(aux_word_q, AUX_WORDS[w]);
			if (w > 0)
				chk(aux_word_index_q, 2'(idx_prev + 2'h1));
			idx_prev = aux_word_index_q;
		end
	endtask : check_aux
	task check_dac;
		int k;
		wait_cyc(7'h50);
		proc_wr = 1'b1;
		proc_wr_dac = 1'b0;
		proc_wdata = DA2_WORD;
		tick;
		proc_wr_dac = 1'b1;
		proc_wdata = DB2_WORD;
		tick;
		proc_wr = 1'b0;
		proc_wdata = ~DB2_WORD;
		wait_cyc(CYC_ZERO);
		for (int c = 0; c < 66; c++) begin
			proc_tx_sdata = (c < 64) ? TX_WORD[31 - c / 2] : ~proc_tx_sdata;
			if (c >= 3 && c % 2 == 1) begin
				k = (c - 3) / 2;
				if (k < 16) begin
					chk(dac_a_sdata_q, TX_WORD[31 - k]);
					chk(dac_a2_sdata_q, DA2_WORD[15 - k]);
					chk(dac_b2_sdata_q, DB2_WORD[15 - k]);
				end else
					chk(dac_b_sdata_q, TX_WORD[31 - k]);
			end
			tick;
		end
	endtask : check_dac
	task check_phase;
		ext_ref_in = 1'b1;
		repeat (8) tick;
		chk({pll_up_q, pll_down_q}, 2'b10);
		sine_square_in = 1'b1;
		repeat (8) tick;
		chk({pll_up_q, pll_down_q}, 2'b00);
		{ext_ref_in, sine_square_in} = 2'b00;
		repeat (4) tick;
		sine_square_in = 1'b1;
		repeat (8) tick;
		chk({pll_up_q, pll_down_q}, 2'b01);
		ext_ref_in = 1'b1;
		repeat (8) tick;
		chk({pll_up_q, pll_down_q}, 2'b00);
	endtask : check_phase
	task check_host;
		host_access(1'b1, HOST_ADDR_MODE, 8'h01);
		chk(cfg_mode_q, 8'h01);
		chk(clk_sel_vco_q, 1'b1);
		host_access(1'b1, HOST_ADDR_AUX_CFG, 8'h5a);
		chk(cfg_aux_q, 8'h5a);
		host_access(1'b0, HOST_ADDR_MODE, 8'h00);
		chk(cfg_mode_q, 8'h01);
		host_access(1'b1, 4'h5, 8'hc7);
		chk(cfg_aux_q, 8'h5a);
		host_access(1'b1, HOST_ADDR_MODE, 8'hfe);
		chk(clk_sel_vco_q, 1'b0);
	endtask : check_host
	// ==========================================
	// main sequence
	initial begin
		{n_mismatch, checks, run_cycles} = '0;
		{srst, ext_ref_in, sine_square_in, proc_tx_sdata, proc_wr, proc_wr_dac} = 6'h20;
		{host_sel, host_write, host_addr, host_data} = '0;
		proc_wdata = 16'h0000;
		aux_tx = 16'h0000;
		repeat (8) @(posedge clock);
		#1 srst = 1'b0;
		check_reset;
		check_cycle_counts;
		check_mux;
		check_aux;
		check_dac;
		check_phase;
		check_host;
		finish_test;
	end
endmodule : lst_timing_tb
